// [src/dps_pkg.sv]
// ----------------------------------------------------------------
// shared constants of the semaphore port controller
// ----------------------------------------------------------------
package dps_pkg;
	// number of flags and width of the flag index
	localparam int FLAG_COUNT = 8;
	localparam int INDEX_W = 3;
	// width of the data pins of one port
	localparam int DATA_W = 8;
	// width of the phase timer
	localparam int TMR_W = 8;

	// clock period in ns
	localparam int CLK_PERIOD_NS = 40;
	// least time the select stays active in one access, ns
	localparam int STROBE_NS = 80;
	// least time all strobes stay inactive between accesses, ns
	localparam int GAP_NS = 40;
	// least times rounded up to whole cycles, never below one
	localparam int STROBE_CYC_RAW = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC_RAW = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
	localparam int GAP_CYC = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;
	// timer load values, one less than the phase length
	localparam logic [TMR_W-1:0] STROBE_LOAD = TMR_W'(STROBE_CYC - 1);
	localparam logic [TMR_W-1:0] GAP_LOAD = TMR_W'(GAP_CYC - 1);

	// last flag index, used by the start-up sweep
	localparam logic [INDEX_W-1:0] LAST_INDEX = 3'h7;
	// first flag index
	localparam logic [INDEX_W-1:0] FIRST_INDEX = 3'h0;

	// operation kinds
	localparam logic [1:0] OP_INIT = 2'h0;
	localparam logic [1:0] OP_ACQ = 2'h1;
	localparam logic [1:0] OP_REL = 2'h2;

	// reset values of the pins: everything inactive
	localparam logic PIN_IDLE = 1'h1;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WRITE = 5'h02,
		ST_READ = 5'h04,
		ST_GAP = 5'h08,
		ST_DONE = 5'h10
	} dps_state_t;
endpackage

// [src/dps_cycle_timer.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// down counter that times one access phase
// ----------------------------------------------------------------
module dps_cycle_timer (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// load strobe and value
	input wire logic load_i,
	input wire logic [dps_pkg::TMR_W-1:0] load_val_i,
	// count has run out
	output logic zero_o
);
	import dps_pkg::*;

	// remaining cycles of the phase
	logic [TMR_W-1:0] count;

	// reload on phase entry, otherwise count down to zero
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
		end else if (load_i) begin
			count <= load_val_i;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	// zero flag read by the sequencer
	assign zero_o = (count == '0);
endmodule

// [src/dps_port_ctrl.sv]
`timescale 1ns/100ps
module dps_port_ctrl (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// user commands, taken while not busy; withdraw_i is sampled in the gap after each failed read
	input wire logic cmd_init_i,
	input wire logic cmd_acquire_i,
	input wire logic cmd_release_i,
	input wire logic [dps_pkg::INDEX_W-1:0] cmd_index_i,
	input wire logic withdraw_i,
	// user status
	output logic busy_o,
	output logic done_o,
	output logic granted_o,
	// semaphore pins of one port
	output logic semaphore_select_n_o,
	output logic rw_n_o,
	output logic oe_n_o,
	output logic [dps_pkg::INDEX_W-1:0] flag_index_lines_o,
	output logic [dps_pkg::DATA_W-1:0] data_o,
	output logic data_oe_o,
	input wire logic [dps_pkg::DATA_W-1:0] data_i
);
	import dps_pkg::*;

	// ------------------------------------------------------------
	// state and sequence registers
	// ------------------------------------------------------------
	dps_state_t state; // current phase
	dps_state_t next_state; // phase for the next cycle
	logic [1:0] op; // operation under way
	logic [INDEX_W-1:0] idx; // flag being accessed
	logic wr_value; // value put on data bit zero
	logic last_read; // the phase before the gap was a read
	logic flag_seen; // flag bit sampled at end of read
	logic tmr_zero; // phase timer has run out

	// ------------------------------------------------------------
	// decoding
	// ------------------------------------------------------------
	wire start_any = cmd_init_i | cmd_acquire_i | cmd_release_i; // any command
	wire phase_end = tmr_zero; // current timed phase ends
	wire init_more = (op == OP_INIT) && (idx != LAST_INDEX); // sweep not finished
	wire acq_write = (op == OP_ACQ) && !wr_value; // claim write just done
	wire claim_ok = !flag_seen; // low flag means we own it
	wire tmr_load = (state != next_state); // new phase starts
	// gap length for the gap, strobe length otherwise
	wire [TMR_W-1:0] tmr_val = (next_state == ST_GAP) ? GAP_LOAD : STROBE_LOAD;
	wire in_access_next = (next_state == ST_WRITE) || (next_state == ST_READ); // select low
	wire write_next = (next_state == ST_WRITE); // write phase next
	wire read_next = (next_state == ST_READ); // read phase next
	wire withdraw_now = (state == ST_GAP) && phase_end && last_read && !claim_ok && withdraw_i;
	// index and write value as they stand after this edge, so that the pins carry them
	// from the very first cycle of a strobe and never a stale flag or value
	wire take_cmd = (state == ST_IDLE) && start_any; // command accepted now
	wire sweep_step = (state == ST_GAP) && phase_end && !last_read && init_more; // next flag
	wire [INDEX_W-1:0] cmd_idx_sel = cmd_init_i ? FIRST_INDEX : cmd_index_i; // start index
	wire [INDEX_W-1:0] next_idx = take_cmd ? cmd_idx_sel : (sweep_step ? idx + 1'b1 : idx);
	wire next_wr = take_cmd ? (cmd_init_i || !cmd_acquire_i) : (withdraw_now || wr_value);

	// ------------------------------------------------------------
	// phase timer
	// ------------------------------------------------------------
	dps_cycle_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(tmr_load),
		.load_val_i(tmr_val),
		.zero_o(tmr_zero)
	);

	// ------------------------------------------------------------
	// next phase
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			// idle: wait for a command
			ST_IDLE: begin
				if (start_any) begin
					next_state = ST_WRITE;
				end
			end
			// write or read phase: hold for the strobe time
			ST_WRITE, ST_READ: begin
				if (phase_end) begin
					next_state = ST_GAP;
				end
			end
			// gap: every access ends with strobes released
			ST_GAP: begin
				if (phase_end) begin
					if (last_read) begin
						if (claim_ok) begin
							next_state = ST_DONE;
						end else if (withdraw_i) begin
							next_state = ST_WRITE;
						end else begin
							next_state = ST_READ;
						end
					end else if (init_more) begin
						next_state = ST_WRITE;
					end else if (acq_write) begin
						next_state = ST_READ;
					end else begin
						next_state = ST_DONE;
					end
				end
			end
			// done: one cycle, then idle
			ST_DONE: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// phase register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// operation, index and write value
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op <= OP_INIT;
			idx <= FIRST_INDEX;
			wr_value <= 1'h1;
		end else if (state == ST_IDLE && start_any) begin
			// init sweeps all flags with one
			if (cmd_init_i) begin
				op <= OP_INIT;
				idx <= FIRST_INDEX;
				wr_value <= 1'h1;
			end else if (cmd_acquire_i) begin
				// claim starts with a zero write
				op <= OP_ACQ;
				idx <= cmd_index_i;
				wr_value <= 1'h0;
			end else begin
				op <= OP_REL;
				idx <= cmd_index_i;
				wr_value <= 1'h1;
			end
		end else if (state == ST_GAP && phase_end && !last_read && init_more) begin
			// step to the next flag of the sweep
			idx <= idx + 1'b1;
		end else if (withdraw_now) begin
			op <= OP_REL;
			wr_value <= 1'h1;
		end
	end

	// ------------------------------------------------------------
	// read tracking and flag sampling
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_read <= 1'h0;
			flag_seen <= 1'h1;
		end else begin
			if (state == ST_WRITE) begin
				last_read <= 1'h0;
			end else if (state == ST_READ) begin
				last_read <= 1'h1;
			end
			if (state == ST_READ && phase_end) begin
				flag_seen <= data_i[0];
			end
		end
	end

	// ------------------------------------------------------------
	// semaphore pins, registered from the next phase
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			semaphore_select_n_o <= PIN_IDLE;
			rw_n_o <= PIN_IDLE;
			oe_n_o <= PIN_IDLE;
			flag_index_lines_o <= FIRST_INDEX;
			data_o <= DATA_RESET;
			data_oe_o <= 1'h0;
		end else begin
			semaphore_select_n_o <= !in_access_next;
			rw_n_o <= !write_next;
			oe_n_o <= !read_next;
			// three index lines address the flag
			flag_index_lines_o <= next_idx;
			// request value on bit zero only
			data_o <= {{(DATA_W-1){1'b0}}, next_wr};
			data_oe_o <= write_next;
		end
	end

	// ------------------------------------------------------------
	// user status
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'h0;
			done_o <= 1'h0;
			granted_o <= 1'h0;
		end else begin
			busy_o <= (next_state != ST_IDLE);
			done_o <= (next_state == ST_DONE);
			// granted only when a claim ends still as a claim
			granted_o <= (next_state == ST_DONE) && (op == OP_ACQ);
		end
	end
endmodule

// [dv/dps_port_monitor.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// pin sequence checker of the port controller
// ------------------------------------------------
module dps_port_monitor (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// user side
	input wire logic cmd_init_i,
	input wire logic cmd_acquire_i,
	input wire logic [dps_pkg::INDEX_W-1:0] cmd_index_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic granted_o,
	// semaphore pins
	input wire logic semaphore_select_n_o,
	input wire logic rw_n_o,
	input wire logic oe_n_o,
	input wire logic [dps_pkg::INDEX_W-1:0] flag_index_lines_o,
	input wire logic [dps_pkg::DATA_W-1:0] data_o,
	input wire logic data_oe_o
);
	import dps_pkg::*;
	// bit zero of the last write strobe
	logic last_wr;
	// remember what the last write left in the latch
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_wr <= 1'h1;
		end else if (!semaphore_select_n_o && !rw_n_o) begin
			last_wr <= data_o[0];
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_read_then_gap:
	assert property ($fell(oe_n_o) |=> !oe_n_o ##1 (oe_n_o && semaphore_select_n_o))
		else $error("read phase not closed by a gap");
	a_write_first:
	assert property ($rose(busy_o) |-> !rw_n_o && !semaphore_select_n_o)
		else $error("command did not open with a write");
	a_fail_withdraws:
	assert property (done_o && !granted_o |-> last_wr)
		else $error("command ended with a request left pending");
	a_sweep_start:
	assert property ($rose(busy_o) && $past(cmd_init_i) |-> flag_index_lines_o == FIRST_INDEX
		&& data_o[0])
		else $error("sweep did not start by freeing flag zero");
	a_claim_zero:
	assert property ($rose(busy_o) && $past(cmd_acquire_i) && !$past(cmd_init_i)
		|-> !data_o[0] && flag_index_lines_o == $past(cmd_index_i))
		else $error("claim did not open with a zero write to its flag");
	a_drive_in_write:
	assert property (data_oe_o == (!semaphore_select_n_o && !rw_n_o) && data_o[7:1] == 7'h00)
		else $error("data drive outside a write or upper data bits set");
endmodule

bind dps_port_ctrl dps_port_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
	.cmd_init_i(cmd_init_i), .cmd_acquire_i(cmd_acquire_i), .cmd_index_i(cmd_index_i),
	.busy_o(busy_o), .done_o(done_o), .granted_o(granted_o),
	.semaphore_select_n_o(semaphore_select_n_o), .rw_n_o(rw_n_o), .oe_n_o(oe_n_o),
	.flag_index_lines_o(flag_index_lines_o), .data_o(data_o), .data_oe_o(data_oe_o));

// [dv/dps_sem_model.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// behavioural two-port semaphore device
// ------------------------------------------------
module dps_sem_model #(
	parameter logic [7:0] INIT_REQ = 8'h00
) (
	// left port, from the controller
	input wire logic l_sel_n_i,
	input wire logic l_rw_n_i,
	input wire logic l_oe_n_i,
	input wire logic [2:0] l_idx_i,
	input wire logic [7:0] l_d_i,
	output logic [7:0] l_d_o,
	// right port, from the bench
	input wire logic r_sel_n_i,
	input wire logic r_rw_n_i,
	input wire logic r_oe_n_i,
	input wire logic [2:0] r_idx_i,
	input wire logic r_d0_i,
	output logic [7:0] r_d_o
);
	// request latches, owner bits and read latches
	logic [7:0] req_l = INIT_REQ, req_r = INIT_REQ, own_l = 8'h00, own_r = 8'h00;
	logic [7:0] q_l = 8'hFF, q_r = 8'hFF;
	task automatic settle(input logic [2:0] i);
		if (own_l[i] && req_l[i]) begin
			own_l[i] = 1'b0;
			own_r[i] = !req_r[i];
		end else if (own_r[i] && req_r[i]) begin
			own_r[i] = 1'b0;
			own_l[i] = !req_l[i];
		end else if (!own_l[i] && !own_r[i]) begin
			own_l[i] = !req_l[i];
			own_r[i] = req_l[i] && !req_r[i];
		end
	endtask
	always @(negedge l_rw_n_i) begin
		#20;
		if (!l_sel_n_i && !l_rw_n_i) begin
			req_l[l_idx_i] = l_d_i[0];
			settle(l_idx_i);
		end
	end
	// right port write, same way
	always @(negedge r_rw_n_i) begin
		#20;
		if (!r_sel_n_i && !r_rw_n_i) begin
			req_r[r_idx_i] = r_d0_i;
			settle(r_idx_i);
		end
	end
	always @(negedge (l_sel_n_i | l_oe_n_i)) q_l = {8{!own_l[l_idx_i]}};
	always @(negedge (r_sel_n_i | r_oe_n_i)) q_r = {8{!own_r[r_idx_i]}};
	// released lines show the inverse of the last value
	assign l_d_o = (!l_sel_n_i && !l_oe_n_i) ? q_l : ~q_l;
	assign r_d_o = (!r_sel_n_i && !r_oe_n_i) ? q_r : ~q_r;
endmodule

// [dv/tb_top.sv]
`timescale 1ns/100ps
// ------------------------------------------------
// bench of the port controller
// ------------------------------------------------
module tb_top;
	import dps_pkg::*;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0;
	logic c_init = 1'b0, c_acq = 1'b0, c_rel = 1'b0, wd = 1'b0;
	logic [2:0] c_idx = 3'h0, r_idx = 3'h0, idx;
	logic r_sel_n = 1'b1, r_rw_n = 1'b1, r_oe_n = 1'b1, r_d0 = 1'b1;
	logic busy, done, grant, sel_n, rw_n, oe_n;
	logic [7:0] d_out, d_in, r_q;
	int errors = 0, n_tests = 0, cyc = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	dps_port_ctrl DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_init_i(c_init),
		.cmd_acquire_i(c_acq), .cmd_release_i(c_rel), .cmd_index_i(c_idx), .withdraw_i(wd),
		.busy_o(busy), .done_o(done), .granted_o(grant), .semaphore_select_n_o(sel_n),
		.rw_n_o(rw_n), .oe_n_o(oe_n), .flag_index_lines_o(idx), .data_o(d_out),
		.data_oe_o(), .data_i(d_in));
	dps_sem_model u_dev (.l_sel_n_i(sel_n), .l_rw_n_i(rw_n), .l_oe_n_i(oe_n), .l_idx_i(idx),
		.l_d_i(d_out), .l_d_o(d_in), .r_sel_n_i(r_sel_n), .r_rw_n_i(r_rw_n),
		.r_oe_n_i(r_oe_n), .r_idx_i(r_idx), .r_d0_i(r_d0), .r_d_o(r_q));
	// compare one value
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// right port write of bit zero
	task automatic r_wr(input logic [2:0] i, input logic v);
		@(posedge sys_clk_i) #1 {r_sel_n, r_rw_n, r_idx, r_d0} = {2'b00, i, v};
		repeat (2) @(posedge sys_clk_i);
		#1 {r_sel_n, r_rw_n} = 2'b11;
	endtask
	// right port read and compare
	task automatic r_rd(input logic [2:0] i, input logic [7:0] exp);
		@(posedge sys_clk_i) #1 {r_sel_n, r_oe_n, r_idx} = {2'b00, i};
		repeat (2) @(posedge sys_clk_i);
		chk("right flag", exp, r_q);
		#1 {r_sel_n, r_oe_n} = 2'b11;
	endtask
	// one controller command, judged at its done pulse
	task automatic run(input logic [2:0] op, input logic [2:0] i, input logic w, input logic g);
		int n;
		@(posedge sys_clk_i) #1 {c_init, c_acq, c_rel, c_idx, wd} = {op, i, w};
		@(posedge sys_clk_i) #1 {c_init, c_acq, c_rel} = 3'h0;
		for (n = 0; n < 400 && done !== 1'b1; n++) @(posedge sys_clk_i) #1;
		chk("done", 8'h01, {7'h00, done});
		chk("granted", {7'h00, g}, {7'h00, grant});
	endtask
	// both ports free every flag at start
	task automatic s_init;
		for (int i = 0; i < 8; i++) r_wr(3'(i), 1'b1);
		run(3'b100, 3'h0, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) r_rd(3'(i), 8'hFF);
	endtask
	// claim, queued request, handover and withdraw
	task automatic s_claim;
		run(3'b010, 3'h2, 1'b0, 1'b1);
		r_rd(3'h2, 8'hFF);
		r_wr(3'h2, 1'b0);
		r_rd(3'h2, 8'hFF);
		run(3'b001, 3'h2, 1'b0, 1'b0);
		r_rd(3'h2, 8'h00);
		run(3'b010, 3'h2, 1'b1, 1'b0);
		r_rd(3'h2, 8'h00);
		r_wr(3'h2, 1'b1);
		r_rd(3'h2, 8'hFF);
	endtask
	// controller polls until the right side lets go
	task automatic s_poll;
		r_wr(3'h5, 1'b0);
		fork
			run(3'b010, 3'h5, 1'b0, 1'b1);
			begin
				repeat (30) @(posedge sys_clk_i);
				r_wr(3'h5, 1'b1);
			end
		join
		r_rd(3'h5, 8'hFF);
	endtask
	// verdict and end of run
	task automatic tally_and_finish;
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk_i);
		#1 rst_n_i = 1'b1;
		s_init;
		s_claim;
		s_poll;
		tally_and_finish;
	end
	// hang guard
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			tally_and_finish;
		end
	end
endmodule
